/* src/bacr_config_regs.sv */
`timescale 1ns/100ps
`include "bacr_defs.svh"
// Configuration bank of the button algorithm, reached through the byte-level
// register port of the serial management front end.
module bacr_config_regs #(
  parameter int DATA_W = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire bacr_pkg::bacr_req_type reg_req,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  output logic reg_ack,
  input wire logic [3:0] btn_pressed,
  input wire logic signed [4*DATA_W-1:0] raw_values,
  output logic [3:0] button_pins,
  output logic signed [4*DATA_W-1:0] processed_button_values,
  output bacr_pkg::bacr_cfg_type cfg
);

  function automatic logic [1:0] scale_of(input logic [7:0] reg_val, input int ch);
    scale_of = reg_val[ch*`BACR_SCALE_BITS +: `BACR_SCALE_BITS];
  endfunction

  logic [7:0] group_r;
  logic [7:0] polarity_r;
  logic [7:0] scale_r;
  logic [7:0] rdata_nxt;

  wire logic hit_group;
  wire logic hit_polarity;
  wire logic hit_scale;
  wire logic hit_any;
  wire logic wr_group;
  wire logic wr_polarity;
  wire logic wr_scale;
  wire bacr_pkg::bacr_cfg_type cfg_nxt;

  wire logic common_group_ch0;
  wire logic common_group_ch1;
  wire logic common_group_ch2;
  wire logic common_group_ch3;

  wire logic deform_group_ch0;
  wire logic deform_group_ch1;
  wire logic deform_group_ch2;
  wire logic deform_group_ch3;

  wire logic btn_out_level_ch0;
  wire logic btn_out_level_ch1;
  wire logic btn_out_level_ch2;
  wire logic btn_out_level_ch3;

  wire logic data_sign_ch0;
  wire logic data_sign_ch1;
  wire logic data_sign_ch2;
  wire logic data_sign_ch3;

  wire logic [1:0] count_scale_ch0;
  wire logic [1:0] count_scale_ch1;
  wire logic [1:0] count_scale_ch2;
  wire logic [1:0] count_scale_ch3;

  assign hit_group = (reg_req.addr == `BACR_ADDR_GROUP);
  assign hit_polarity = (reg_req.addr == `BACR_ADDR_POLARITY);
  assign hit_scale = (reg_req.addr == `BACR_ADDR_SCALE);
  assign hit_any = hit_group | hit_polarity | hit_scale;
  assign wr_group = reg_req.wr_en & hit_group;
  assign wr_polarity = reg_req.wr_en & hit_polarity;
  assign wr_scale = reg_req.wr_en & hit_scale;

  // Reads of unmapped offsets return zero; a write there is dropped.
  always_comb
  begin
    rdata_nxt = `BACR_UNMAPPED_READ;
    if (hit_group)
    begin
      rdata_nxt = group_r;
    end
    else if (hit_polarity)
    begin
      rdata_nxt = polarity_r;
    end
    else if (hit_scale)
    begin
      rdata_nxt = scale_r;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      group_r <= `BACR_RST_GROUP;
    end
    else if (wr_group)
    begin
      group_r <= reg_req.wdata;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      polarity_r <= `BACR_RST_POLARITY;
    end
    else if (wr_polarity)
    begin
      polarity_r <= reg_req.wdata;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      scale_r <= `BACR_RST_SCALE;
    end
    else if (wr_scale)
    begin
      scale_r <= reg_req.wdata;
    end
  end

  // Read data is taken in the request cycle, so a read and a write to the
  // same offset in one cycle returns the old value.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      reg_rd_valid <= 1'b0;
      reg_ack <= 1'b0;
    end
    else
    begin
      reg_rd_valid <= reg_req.rd_en;
      reg_ack <= (reg_req.rd_en | reg_req.wr_en) & hit_any;
    end
  end

  // Read data holds between reads, so a slow host may pick it up late.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      reg_rdata <= 8'h00;
    end
    else if (reg_req.rd_en)
    begin
      reg_rdata <= rdata_nxt;
    end
  end

  // Per-channel views of the three registers, named for what each field steers.
  assign common_group_ch0 = group_r[`BACR_COMMON_LSB + 0];
  assign common_group_ch1 = group_r[`BACR_COMMON_LSB + 1];
  assign common_group_ch2 = group_r[`BACR_COMMON_LSB + 2];
  assign common_group_ch3 = group_r[`BACR_COMMON_LSB + 3];

  assign deform_group_ch0 = group_r[`BACR_DEFORM_LSB + 0];
  assign deform_group_ch1 = group_r[`BACR_DEFORM_LSB + 1];
  assign deform_group_ch2 = group_r[`BACR_DEFORM_LSB + 2];
  assign deform_group_ch3 = group_r[`BACR_DEFORM_LSB + 3];

  assign btn_out_level_ch0 = polarity_r[`BACR_OUT_LEVEL_LSB + 0];
  assign btn_out_level_ch1 = polarity_r[`BACR_OUT_LEVEL_LSB + 1];
  assign btn_out_level_ch2 = polarity_r[`BACR_OUT_LEVEL_LSB + 2];
  assign btn_out_level_ch3 = polarity_r[`BACR_OUT_LEVEL_LSB + 3];

  assign data_sign_ch0 = polarity_r[`BACR_DATA_SIGN_LSB + 0];
  assign data_sign_ch1 = polarity_r[`BACR_DATA_SIGN_LSB + 1];
  assign data_sign_ch2 = polarity_r[`BACR_DATA_SIGN_LSB + 2];
  assign data_sign_ch3 = polarity_r[`BACR_DATA_SIGN_LSB + 3];

  assign count_scale_ch0 = scale_of(scale_r, 0);
  assign count_scale_ch1 = scale_of(scale_r, 1);
  assign count_scale_ch2 = scale_of(scale_r, 2);
  assign count_scale_ch3 = scale_of(scale_r, 3);

  assign cfg_nxt.common_group = {common_group_ch3, common_group_ch2,
                                 common_group_ch1, common_group_ch0};
  assign cfg_nxt.deform_group = {deform_group_ch3, deform_group_ch2,
                                 deform_group_ch1, deform_group_ch0};
  assign cfg_nxt.btn_out_level = {btn_out_level_ch3, btn_out_level_ch2,
                                  btn_out_level_ch1, btn_out_level_ch0};
  assign cfg_nxt.data_sign = {data_sign_ch3, data_sign_ch2,
                              data_sign_ch1, data_sign_ch0};
  assign cfg_nxt.count_scale = {count_scale_ch3, count_scale_ch2,
                                count_scale_ch1, count_scale_ch0};

  // The algorithm sees the settings one cycle after a write lands.
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      cfg <= {`BACR_RST_GROUP, `BACR_RST_POLARITY, `BACR_RST_SCALE};
    end
    else
    begin
      cfg <= cfg_nxt;
    end
  end

  genvar ch;
  generate
    for (ch = 0; ch < `BACR_NUM_CH; ch = ch + 1)
    begin : g_chan
      bacr_chan_out #(
        .DATA_W(DATA_W)
      ) u_chan (
        .clk(clk),
        .reset(reset),
        .btn_pressed(btn_pressed[ch]),
        .btn_out_level(polarity_r[`BACR_OUT_LEVEL_LSB + ch]),
        .data_sign(polarity_r[`BACR_DATA_SIGN_LSB + ch]),
        .raw_value(raw_values[ch*DATA_W +: DATA_W]),
        .button_pin(button_pins[ch]),
        .processed_button_value(processed_button_values[ch*DATA_W +: DATA_W])
      );
    end
  endgenerate

endmodule // bacr_config_regs

/* src/bacr_defs.svh */
`ifndef BACR_DEFS_SVH
`define BACR_DEFS_SVH
// Behaviour
// - Bits 7..4 of group register put channels 3..0 in the common-mode group.
// - Bits 3..0 of group register put channels 3..0 in the deformation group.
// - Group register at 0x1A resets to 0x00, no channel in any group.
// - Bits 7..4 of polarity register set button pins 3..0 active high when 1.
// - Bits 3..0 make processed data rise with frequency when 1, fall when 0.
// - Polarity register at 0x1C resets to 0x0F.
// - Two-bit counter scale per channel, bits 7-6 channel 3 down to 1-0 channel 0.
// - Counter scale register at 0x1E resets to 0x55, scale 1 everywhere.

`define BACR_ADDR_GROUP 8'h1A
`define BACR_ADDR_POLARITY 8'h1C
`define BACR_ADDR_SCALE 8'h1E

`define BACR_RST_GROUP 8'h00
`define BACR_RST_POLARITY 8'h0F
`define BACR_RST_SCALE 8'h55

`define BACR_COMMON_LSB 4
`define BACR_DEFORM_LSB 0
`define BACR_OUT_LEVEL_LSB 4
`define BACR_DATA_SIGN_LSB 0
`define BACR_SCALE_BITS 2

`define BACR_UNMAPPED_READ 8'h00
`define BACR_NUM_CH 4
`endif

/* src/bacr_pkg.sv */
package bacr_pkg;

  typedef struct packed {
    logic [3:0] common_group;
    logic [3:0] deform_group;
    logic [3:0] btn_out_level;
    logic [3:0] data_sign;
    logic [7:0] count_scale;
  } bacr_cfg_type;

  typedef struct packed {
    logic [7:0] addr;
    logic wr_en;
    logic rd_en;
    logic [7:0] wdata;
  } bacr_req_type;

endpackage

/* src/bacr_chan_out.sv */
`timescale 1ns/100ps
// One channel's pin level and data sign stage; both outputs are registered.
module bacr_chan_out #(
  parameter int DATA_W = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic btn_pressed,
  input wire logic btn_out_level,
  input wire logic data_sign,
  input wire logic signed [DATA_W-1:0] raw_value,
  output logic button_pin,
  output logic signed [DATA_W-1:0] processed_button_value
);

  localparam logic signed [DATA_W-1:0] MOST_NEG = {1'b1, {(DATA_W-1){1'b0}}};
  localparam logic signed [DATA_W-1:0] MOST_POS = {1'b0, {(DATA_W-1){1'b1}}};

  wire logic pin_nxt;
  wire logic signed [DATA_W-1:0] negated;
  wire logic signed [DATA_W-1:0] value_nxt;

  // A pressed button drives the pin to its selected active level.
  assign pin_nxt = btn_pressed ? btn_out_level : ~btn_out_level;
  // Negation saturates so the most negative input cannot wrap to itself.
  assign negated = (raw_value == MOST_NEG) ? MOST_POS : -raw_value;
  assign value_nxt = data_sign ? raw_value : negated;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      // The pin idles inactive for the reset polarity, which is active low.
      button_pin <= 1'b1;
      processed_button_value <= '0;
    end
    else
    begin
      button_pin <= pin_nxt;
      processed_button_value <= value_nxt;
    end
  end

endmodule // bacr_chan_out

/* test/bacr_config_regs_monitor.sv */
`timescale 1ns/100ps
module bacr_config_regs_monitor (
  input wire logic clk,
  input wire logic reset,
  input wire bacr_pkg::bacr_req_type reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_valid,
  input wire logic reg_ack,
  input wire logic [3:0] btn_pressed,
  input wire logic [3:0] button_pins,
  input wire bacr_pkg::bacr_cfg_type cfg
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  wire logic [7:0] a = reg_req.addr;
  wire logic hit = a == 8'h1a || a == 8'h1c || a == 8'h1e;
  sequence wr_to(logic [7:0] x);
    reg_req.wr_en && a == x;
  endsequence
  a_group_write: assert property (wr_to(8'h1a) |-> ##2 cfg[23:16] == $past(reg_req.wdata, 2))
    else $error("group write lost");
  a_pol_write: assert property (wr_to(8'h1c) |-> ##2 cfg[15:8] == $past(reg_req.wdata, 2))
    else $error("polarity write lost");
  a_scale_write: assert property (wr_to(8'h1e) |-> ##2 cfg.count_scale == $past(reg_req.wdata, 2))
    else $error("scale write lost");
  a_ack_mapped: assert property ((reg_req.wr_en || reg_req.rd_en) && hit |=> reg_ack)
    else $error("no ack");
  a_unmapped_read: assert property (reg_req.rd_en && !hit |=> reg_rd_valid && !reg_ack && reg_rdata == 8'h00)
    else $error("unmapped read");
  a_scale_read: assert property (reg_req.rd_en && a == 8'h1e |=> reg_rdata == cfg.count_scale)
    else $error("scale read");
  a_pin_level: assert property (button_pins == ~($past(btn_pressed) ^ cfg.btn_out_level))
    else $error("pin level");
  a_reset_vals: assert property ($fell(reset) |-> cfg == {8'h00, 8'h0f, 8'h55})
    else $error("reset values");
endmodule // bacr_config_regs_monitor

bind bacr_config_regs bacr_config_regs_monitor bacr_config_regs_monitor_i (.clk(clk), .reset(reset),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .reg_ack(reg_ack),
  .btn_pressed(btn_pressed), .button_pins(button_pins), .cfg(cfg));

/* test/bacr_host.sv */
`timescale 1ns/100ps
module bacr_host (
  input wire logic clk,
  output bacr_pkg::bacr_req_type req
);
  initial req = '0;
  // One strobe per transfer; the released bus shows inverted values so stale data cannot pass.
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{a, w, !w, d};
    @(posedge clk);
    req <= '{~a, 1'b0, 1'b0, ~d};
  endtask
endmodule // bacr_host

/* test/button_algo_config_regs_tb.sv */
`timescale 1ns/100ps
module button_algo_config_regs_tb;
  logic clk = 0;
  logic reset = 1;
  logic [3:0] btn = 4'h0;
  logic [63:0] raw = 64'h0;
  logic [3:0] pins;
  logic [63:0] pv;
  logic [7:0] rdata;
  logic rv;
  logic ack;
  bacr_pkg::bacr_req_type req;
  bacr_pkg::bacr_cfg_type cfg;
  int bad_count = 0;
  int n_tests = 0;
  always #20 clk = ~clk;
  bacr_host bacr_host_i (.clk(clk), .req(req));
  bacr_config_regs bacr_config_regs_i (.clk(clk), .reset(reset), .reg_req(req), .reg_rdata(rdata),
    .reg_rd_valid(rv), .reg_ack(ack), .btn_pressed(btn), .raw_values(raw), .button_pins(pins),
    .processed_button_values(pv), .cfg(cfg));
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %0t %h %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    bacr_host_i.xfer(w, a, d);
    #1 chk({rv, ack}, {!w, a inside {8'h1a, 8'h1c, 8'h1e}});
    if (!w)
      chk(rdata, d);
  endtask
  task automatic t_reset();
    acc(0, 8'h1a, 8'h00);
    acc(0, 8'h1c, 8'h0f);
    acc(0, 8'h1e, 8'h55);
    chk(pins, 4'hf);
    chk(cfg, 24'h00_0f55);
  endtask
  task automatic t_regs();
    acc(1, 8'h1a, 8'ha5);
    acc(1, 8'h1e, 8'he4);
    acc(1, 8'h1b, 8'hff);
    acc(0, 8'h1a, 8'ha5);
    acc(0, 8'h1e, 8'he4);
    acc(0, 8'h1b, 8'h00);
    chk(cfg, 24'ha5_0fe4);
  endtask
  task automatic t_pins();
    acc(1, 8'h1c, 8'h5a);
    @(posedge clk);
    btn <= 4'h3;
    raw <= 64'h0007_fff7_fffb_0064;
    @(posedge clk);
    #1 chk(pins, 4'h9);
    chk(pv, 64'h0007_0009_fffb_ff9c);
    chk(cfg, 24'ha5_5ae4);
    @(posedge clk);
    raw <= 64'h0000_8000_0000_0000;
    @(posedge clk);
    #1 chk(pv, 64'h0000_7fff_0000_0000);
  endtask
  task automatic end_of_test();
    if (bad_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(posedge clk);
    reset <= 0;
    t_reset();
    t_regs();
    t_pins();
    end_of_test();
  end
endmodule // button_algo_config_regs_tb
